// ### hw/pwm_dtc_pkg.sv
// constants and types for the dead-time compensated pwm channel
// Function
// - compensation on in edge mode: polarity bits and input choose add or subtract
// - subtracting: duty minus twice dead time below zero forces 0%
// - adding: duty plus twice dead time at or above period forces 100%
// - duty source: channel duty when select bit 8 is 0, master duty otherwise
// - period from primary, secondary or phase value by bits 9 and 3
// - alternate dead time kept out of limits, inserted when not forced
// - center mode compensation widens both low-side edges by half alternate dead time
// - center mode compensation leaves high-side edges untouched
package pwm_dtc_pkg;
    localparam int          CNT_W        = 16;
    localparam int          EXT_W        = 18;
    // control word fields
    localparam int          TB_SEL_BIT   = 3;
    localparam int          CENTER_BIT   = 2;
    localparam int          COMP_EN_LO   = 4;
    localparam int          COMP_EN_HI   = 5;
    localparam int          POL_LO       = 6;
    localparam int          POL_HI       = 7;
    localparam int          DUTY_SRC_BIT = 8;
    localparam int          INDEP_TB_BIT = 9;
    localparam logic [1:0]  COMP_ON      = 2'h3;
    // reset and boundary values
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [1:0]       EXT_PAD  = 2'h0;
    localparam logic             SYNC_RST = 1'h0;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_e;
endpackage : pwm_dtc_pkg

// ### hw/dir_sync_if.sv
// carrier for the compensation input between the channel and its synchroniser
`timescale 1ns/100ps
interface dir_sync_if;
    logic raw;
    logic level;
    modport sync_side (input raw, output level);
    modport user_side (output raw, input level);
endinterface : dir_sync_if

// ### hw/dir_input_sync.sv
// three-stage synchroniser for the compensation direction pin
`timescale 1ns/100ps
module dir_input_sync (
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // synchronised pin
    dir_sync_if.sync_side  pin
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1_reg <= pwm_dtc_pkg::SYNC_RST;
            stage2_reg <= pwm_dtc_pkg::SYNC_RST;
            stage3_reg <= pwm_dtc_pkg::SYNC_RST;
        end else begin
            stage1_reg <= pin.raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            level_reg <= pwm_dtc_pkg::SYNC_RST;
        end else if (stage2_reg == stage3_reg) begin
            level_reg <= stage3_reg;
        end
    end

    assign pin.level = level_reg;
endmodule : dir_input_sync

// ### hw/pwm_dead_time_compensation.sv
// pwm channel with time base, dead time and dead-time compensation
`timescale 1ns/100ps
module pwm_dead_time_compensation (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // configuration
    input  wire logic [15:0] channel_control_word,
    // timing values
    input  wire logic [15:0] channel_duty_value,
    input  wire logic [15:0] master_duty_value,
    input  wire logic [15:0] primary_period_value,
    input  wire logic [15:0] secondary_period_value,
    input  wire logic [15:0] channel_phase_value,
    input  wire logic [15:0] dead_time_value,
    input  wire logic [15:0] alternate_dead_time,
    // compensation sense pin
    input  wire logic        comp_direction_input,
    // power stage drive
    output logic             high_side_output,
    output logic             low_side_output,
    // status
    output logic             force_zero_active,
    output logic             force_full_active,
    output logic             comp_adding
);
    localparam int CW = pwm_dtc_pkg::CNT_W;
    localparam int EW = pwm_dtc_pkg::EXT_W;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [EW-1:0] widen(input logic [CW-1:0] v);
        widen = {pwm_dtc_pkg::EXT_PAD, v};
    endfunction : widen

    ////////////////////////////////////////////////////////////////////////////
    // control word decode

    logic [1:0] comp_enable_field;
    logic [1:0] comp_polarity_bits;
    logic       center_align_select;
    logic       duty_source_select;
    logic       independent_timebase_select;
    logic       master_timebase_select;
    logic       comp_on;

    assign comp_enable_field           = channel_control_word[pwm_dtc_pkg::COMP_EN_HI:pwm_dtc_pkg::COMP_EN_LO];
    assign comp_polarity_bits          = channel_control_word[pwm_dtc_pkg::POL_HI:pwm_dtc_pkg::POL_LO];
    assign center_align_select         = channel_control_word[pwm_dtc_pkg::CENTER_BIT];
    assign duty_source_select          = channel_control_word[pwm_dtc_pkg::DUTY_SRC_BIT];
    assign independent_timebase_select = channel_control_word[pwm_dtc_pkg::INDEP_TB_BIT];
    assign master_timebase_select      = channel_control_word[pwm_dtc_pkg::TB_SEL_BIT];
    assign comp_on                     = (comp_enable_field == pwm_dtc_pkg::COMP_ON);

    ////////////////////////////////////////////////////////////////////////////
    // compensation input synchroniser

    dir_sync_if dir_bus ();

    assign dir_bus.raw = comp_direction_input;

    dir_input_sync u_dir_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (dir_bus.sync_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source selection and compensation arithmetic

    logic [CW-1:0] duty_sel;
    logic [CW-1:0] period_sel;
    logic          add_dir;
    logic [EW-1:0] two_dt;
    logic [EW-1:0] duty_plus;
    logic [EW-1:0] duty_minus;
    logic          minus_neg;
    logic          plus_full;
    logic [CW-1:0] eff_duty;
    logic          force_zero;
    logic          force_full;

    assign duty_sel = duty_source_select ? master_duty_value : channel_duty_value;

    always_comb begin
        if (independent_timebase_select) begin
            period_sel = channel_phase_value;
        end else if (master_timebase_select) begin
            period_sel = secondary_period_value;
        end else begin
            period_sel = primary_period_value;
        end
    end

    // bit 1 fixes the direction by bit 0; otherwise bit 0 inverts the pin sense
    assign add_dir = comp_polarity_bits[1] ? comp_polarity_bits[0]
                                           : (dir_bus.level ^ comp_polarity_bits[0]);

    assign two_dt     = {1'b0, dead_time_value, 1'b0};
    assign duty_plus  = widen(duty_sel) + two_dt;
    assign duty_minus = widen(duty_sel) - two_dt;
    assign minus_neg  = widen(duty_sel) < two_dt;
    assign plus_full  = duty_plus >= widen(period_sel);

    // alternate dead time takes no part in the limit decisions
    always_comb begin
        force_zero = 1'b0;
        force_full = 1'b0;
        eff_duty   = duty_sel;
        if (comp_on && !center_align_select) begin
            if (add_dir) begin
                force_full = plus_full;
                eff_duty   = duty_plus[CW-1:0];
            end else begin
                force_zero = minus_neg;
                eff_duty   = duty_minus[CW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time base

    logic                    [CW-1:0] cnt_reg;
    logic                    [CW-1:0] cnt_next;
    pwm_dtc_pkg::count_dir_e          dir_reg;
    pwm_dtc_pkg::count_dir_e          dir_next;
    logic                    [CW-1:0] period_reg;
    logic                             center_reg;
    logic                             boundary;

    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        boundary = 1'b0;
        if (!center_reg) begin
            dir_next = pwm_dtc_pkg::DIR_UP;
            if (period_reg == pwm_dtc_pkg::CNT_ZERO || cnt_reg >= period_reg - pwm_dtc_pkg::CNT_ONE) begin
                cnt_next = pwm_dtc_pkg::CNT_ZERO;
                boundary = 1'b1;
            end else begin
                cnt_next = cnt_reg + pwm_dtc_pkg::CNT_ONE;
            end
        end else begin
            unique case (dir_reg)
                pwm_dtc_pkg::DIR_UP: begin
                    if (cnt_reg >= period_reg) begin
                        dir_next = pwm_dtc_pkg::DIR_DOWN;
                        cnt_next = (cnt_reg == pwm_dtc_pkg::CNT_ZERO) ? cnt_reg : cnt_reg - pwm_dtc_pkg::CNT_ONE;
                        boundary = (cnt_reg == pwm_dtc_pkg::CNT_ZERO);
                    end else begin
                        cnt_next = cnt_reg + pwm_dtc_pkg::CNT_ONE;
                    end
                end
                pwm_dtc_pkg::DIR_DOWN: begin
                    if (cnt_reg <= pwm_dtc_pkg::CNT_ONE) begin
                        dir_next = pwm_dtc_pkg::DIR_UP;
                        cnt_next = pwm_dtc_pkg::CNT_ZERO;
                        boundary = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - pwm_dtc_pkg::CNT_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= pwm_dtc_pkg::CNT_ZERO;
            dir_reg <= pwm_dtc_pkg::DIR_UP;
        end else begin
            cnt_reg <= cnt_next;
            dir_reg <= dir_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-cycle parameter latch, taken only at the cycle boundary to avoid runt pulses

    logic [CW-1:0] eff_duty_reg;
    logic [CW-1:0] alt_reg;
    logic          comp_reg;
    logic          force_zero_reg;
    logic          force_full_reg;
    logic          adding_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            period_reg     <= pwm_dtc_pkg::CNT_ZERO;
            eff_duty_reg   <= pwm_dtc_pkg::CNT_ZERO;
            alt_reg        <= pwm_dtc_pkg::CNT_ZERO;
            center_reg     <= 1'b0;
            comp_reg       <= 1'b0;
            force_zero_reg <= 1'b0;
            force_full_reg <= 1'b0;
            adding_reg     <= 1'b0;
        end else if (boundary) begin
            period_reg     <= period_sel;
            eff_duty_reg   <= eff_duty;
            alt_reg        <= alternate_dead_time;
            center_reg     <= center_align_select;
            comp_reg       <= comp_on;
            force_zero_reg <= force_zero;
            force_full_reg <= force_full;
            adding_reg     <= comp_on && !center_align_select && add_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pair generation

    logic [EW-1:0] cnt_ext;
    logic [EW-1:0] half_alt;
    logic          high_next;
    logic          low_next;

    assign cnt_ext  = widen(cnt_reg);
    assign half_alt = widen({1'b0, alt_reg[CW-1:1]});

    always_comb begin
        high_next = 1'b0;
        low_next  = 1'b0;
        if (!center_reg) begin
            if (force_zero_reg) begin
                low_next  = 1'b1;
            end else if (force_full_reg) begin
                high_next = 1'b1;
            end else begin
                high_next = (cnt_reg >= alt_reg) && (cnt_reg < eff_duty_reg);
                low_next  = cnt_ext >= widen(eff_duty_reg) + widen(alt_reg);
            end
        end else if (comp_reg) begin
            high_next = cnt_reg < eff_duty_reg;
            low_next  = cnt_ext + half_alt >= widen(eff_duty_reg);
        end else begin
            high_next = cnt_ext + widen(alt_reg) < widen(eff_duty_reg);
            low_next  = cnt_reg >= eff_duty_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            high_side_output <= 1'b0;
            low_side_output  <= 1'b0;
        end else begin
            high_side_output <= high_next;
            low_side_output  <= low_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            force_zero_active <= 1'b0;
            force_full_active <= 1'b0;
            comp_adding       <= 1'b0;
        end else begin
            force_zero_active <= force_zero_reg;
            force_full_active <= force_full_reg;
            comp_adding       <= adding_reg;
        end
    end
endmodule : pwm_dead_time_compensation

// ### sim/pwm_dtc_monitor.sv
// assertion checker for the dead-time compensated pwm channel
`timescale 1ns/100ps
module pwm_dtc_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // configuration and timing
    input wire logic [15:0] channel_control_word,
    input wire logic [15:0] channel_duty_value,
    input wire logic [15:0] master_duty_value,
    input wire logic [15:0] primary_period_value,
    input wire logic [15:0] secondary_period_value,
    input wire logic [15:0] channel_phase_value,
    input wire logic [15:0] dead_time_value,
    input wire logic [15:0] alternate_dead_time,
    input wire logic        comp_direction_input,
    // drive and status
    input wire logic        high_side_output,
    input wire logic        low_side_output,
    input wire logic        force_zero_active,
    input wire logic        force_full_active,
    input wire logic        comp_adding
);
    logic [7:0]  run_cnt;
    logic [17:0] duty_sel;
    logic [17:0] per_sel;
    logic [17:0] twice_dt;
    logic        edge_comp;
    logic        center_comp;
    logic        dir_add;
    logic        settled;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // cycles since reset release, saturating
    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_cnt <= 8'h00;
        end else if (run_cnt != 8'hff) begin
            run_cnt <= run_cnt + 8'h01;
        end
    end

    always_comb begin
        duty_sel    = {2'h0, channel_control_word[8] ? master_duty_value : channel_duty_value};
        per_sel     = {2'h0, channel_control_word[9] ? channel_phase_value
                    : channel_control_word[3] ? secondary_period_value : primary_period_value};
        twice_dt    = {1'h0, dead_time_value, 1'h0};
        edge_comp   = channel_control_word[5:4] == pwm_dtc_pkg::COMP_ON && !channel_control_word[2];
        center_comp = channel_control_word[5:4] == pwm_dtc_pkg::COMP_ON && channel_control_word[2];
        dir_add     = channel_control_word[7] ? channel_control_word[6]
                    : comp_direction_input ^ channel_control_word[6];
        settled     = run_cnt > 8'h3b;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_flags_exclusive: assert property (!(force_zero_active && force_full_active))
        else $error("zero and full forcing at once");
    a_zero_cause: assert property (settled && force_zero_active |-> edge_comp && duty_sel < twice_dt)
        else $error("zero forcing without its cause");
    a_full_cause: assert property (settled && force_full_active |-> comp_adding && duty_sel + twice_dt >= per_sel)
        else $error("full forcing without its cause");
    a_zero_drive: assert property (force_zero_active && $past(force_zero_active) |-> low_side_output && !high_side_output)
        else $error("zero forcing not seen on drive pair");
    a_full_drive: assert property (force_full_active && $past(force_full_active) |-> high_side_output && !low_side_output)
        else $error("full forcing not seen on drive pair");
    a_add_direction: assert property (settled |-> comp_adding == (edge_comp && dir_add))
        else $error("add direction wrong");
    a_no_overlap: assert property (!center_comp |-> !(high_side_output && low_side_output))
        else $error("both sides on outside center compensation");
    a_center_widen: assert property (settled && center_comp && alternate_dead_time > 16'h0001
        && ($rose(low_side_output) || $fell(low_side_output)) |-> high_side_output)
        else $error("low edge not widened over high side");
    c_force_zero: cover property (force_zero_active);
    c_force_full: cover property (force_full_active);
    c_center_overlap: cover property (center_comp && high_side_output && low_side_output);
endmodule : pwm_dtc_monitor

bind pwm_dead_time_compensation pwm_dtc_monitor u_mon (.core_clk, .rst, .channel_control_word, .channel_duty_value,
    .master_duty_value, .primary_period_value, .secondary_period_value, .channel_phase_value, .dead_time_value,
    .alternate_dead_time, .comp_direction_input, .high_side_output, .low_side_output, .force_zero_active,
    .force_full_active, .comp_adding);

// ### sim/comp_sense_model.sv
// compensation sense source seen by the pwm channel
`timescale 1ns/100ps
module comp_sense_model (
    // clock
    input wire logic core_clk,
    // requested level and speed
    input wire logic sense_req,
    input wire logic slow,
    // sense pin
    output logic     sense_pin
);
    logic [3:0] lag_reg = 4'h0;

    always_ff @(posedge core_clk) begin
        lag_reg <= {lag_reg[2:0], sense_req};
    end
    // a slow sense settles several clocks after the request
    assign sense_pin = slow ? lag_reg[3] : lag_reg[0];
endmodule : comp_sense_model

// ### sim/tb.sv
// self-checking bench for the dead-time compensated pwm channel
`timescale 1ns/100ps
module tb;
    logic        core_clk               = 1'b0;
    logic        rst                    = 1'b1;
    logic [15:0] channel_control_word   = 16'h0000;
    logic [15:0] channel_duty_value     = 16'h0000;
    logic [15:0] master_duty_value      = 16'h0000;
    logic [15:0] primary_period_value   = 16'h0000;
    logic [15:0] secondary_period_value = 16'h0000;
    logic [15:0] channel_phase_value    = 16'h0000;
    logic [15:0] dead_time_value        = 16'h0000;
    logic [15:0] alternate_dead_time    = 16'h0000;
    logic        sense_req              = 1'b0;
    logic        slow                   = 1'b0;
    logic        comp_direction_input;
    logic        high_side_output, low_side_output, force_zero_active, force_full_active, comp_adding;
    logic [31:0] seed                   = 32'h4625;
    int          n_mismatch             = 0;
    int          total_checks           = 0;
    // expected drive counts of the reference model, oldest first
    int          exp_q[$];

    always #50 core_clk = ~core_clk;

    comp_sense_model u_sense (.core_clk, .sense_req, .slow, .sense_pin(comp_direction_input));
    pwm_dead_time_compensation uut (.core_clk, .rst, .channel_control_word, .channel_duty_value, .master_duty_value,
        .primary_period_value, .secondary_period_value, .channel_phase_value, .dead_time_value, .alternate_dead_time,
        .comp_direction_input, .high_side_output, .low_side_output, .force_zero_active, .force_full_active,
        .comp_adding);

    function automatic int rnd(input int m);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return int'(seed[15:0]) % m;
    endfunction : rnd

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // apply one setting under reset, let it settle, count drive over one pwm cycle
    task automatic run(input logic [15:0] c, input int d, input int p, input int t, input int a, input logic pin);
        int       hi, lo, w, eh, el, eff;
        logic     on, add, fz, ff;
        @(posedge core_clk);
        #1;
        rst = 1'b1;
        channel_control_word = c;
        channel_duty_value = c[8] ? 16'(rnd(99)) : 16'(d);
        master_duty_value = c[8] ? 16'(d) : 16'(rnd(99));
        primary_period_value = (c[9] || c[3]) ? 16'(rnd(99)) : 16'(p);
        secondary_period_value = (c[9] || !c[3]) ? 16'(rnd(99)) : 16'(p);
        channel_phase_value = c[9] ? 16'(p) : 16'(rnd(99));
        dead_time_value = 16'(t);
        alternate_dead_time = 16'(a);
        sense_req = pin;
        slow = rnd(2) == 1;
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (64) @(posedge core_clk);
        on = c[5:4] == 2'h3 && !c[2];
        add = on && (c[7] ? c[6] : pin ^ c[6]);
        fz = on && !add && d < 2 * t;
        ff = add && d + 2 * t >= p;
        eff = !on ? d : add ? d + 2 * t : d - 2 * t;
        w = c[2] ? 2 * p : p;
        if (c[2]) begin
            eh = c[5:4] == 2'h3 ? 2 * d - 1 : 2 * (d - a) - 1;
            el = c[5:4] == 2'h3 ? 2 * (p - d + a / 2) + 1 : 2 * (p - d) + 1;
        end else begin
            eh = fz ? 0 : ff ? p : (eff < p ? eff : p) - a;
            el = fz ? p : ff ? 0 : p - eff - a;
        end
        eh = eh < 0 ? 0 : eh;
        el = el < 0 ? 0 : el;
        exp_q.push_back(eh);
        exp_q.push_back(el);
        hi = 0;
        lo = 0;
        repeat (w) begin
            @(posedge core_clk);
            #1;
            hi += int'(high_side_output === 1'b1);
            lo += int'(low_side_output === 1'b1);
        end
        check("high_count", 32'(hi), 32'(exp_q.pop_front()));
        check("low_count", 32'(lo), 32'(exp_q.pop_front()));
        check("force_zero", {31'h0, force_zero_active}, {31'h0, fz});
        check("force_full", {31'h0, force_full_active}, {31'h0, ff});
        check("adding", {31'h0, comp_adding}, {31'h0, add});
    endtask : run

    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        int c, p, a;
        repeat (20) @(posedge core_clk);
        run(16'h00b0, 3, 16, 4, 2, 1'b0);
        run(16'h01f0, 10, 16, 3, 2, 1'b0);
        run(16'h02f0, 9, 16, 3, 2, 1'b1);
        run(16'h00b8, 8, 16, 4, 2, 1'b0);
        run(16'h0034, 7, 12, 1, 4, 1'b0);
        run(16'h0004, 7, 12, 1, 4, 1'b0);
        run(16'h0030, 6, 20, 2, 2, 1'b1);
        run(16'h0070, 9, 20, 2, 2, 1'b1);
        for (int i = 0; i < 14; i++) begin
            c = rnd(1024) & 'h3fc;
            p = 8 + rnd(16);
            a = 2 * rnd(3);
            run(16'(c), c[2] ? a + 1 + rnd(p - a - 1) : rnd(p + 6), p, rnd(6), a, rnd(2) == 1);
        end
        report_and_stop();
    end
endmodule : tb
